//--- xmem_lat_pkg.sv
// constants and types for the external memory access latency block
package xmem_lat_pkg;
	localparam int unsigned SYS_CLK_HZ      = 10000000;
	localparam int unsigned PIPE_THRESH_HZ  = 40000000;
	localparam logic [31:0] CACHE_LO        = 32'hc0000000;
	localparam logic [31:0] CACHE_HI        = 32'hd1000000;
	localparam logic [3:0]  CACHE_ALIAS_MSK = 4'h3;
	localparam int unsigned LINE_WORDS      = 4;
	localparam logic [7:0]  SD_RD_W8        = 8'h07;
	localparam logic [7:0]  SD_RD_W16       = 8'h05;
	localparam logic [7:0]  SD_RD_W32       = 8'h04;
	localparam logic [7:0]  SD_RD_B16       = 8'h04;
	localparam logic [7:0]  SD_RD_H8        = 8'h05;
	localparam logic [7:0]  SD_WR           = 8'h02;
	localparam logic [7:0]  SD_FILL_W8      = 8'h15;
	localparam logic [7:0]  SD_FILL_W16     = 8'h0d;
	localparam logic [7:0]  SD_FILL_W32     = 8'h09;
	localparam logic [7:0]  FILL_BASE       = 8'h03;
	localparam logic [7:0]  NONSEQ_EXTRA    = 8'h01;
	localparam logic [7:0]  PIPE_EXTRA      = 8'h01;
	localparam logic [7:0]  DMA_WAIT        = 8'h01;
	localparam logic [7:0]  TURN_CYC        = 8'h01;

	typedef enum logic [1:0] {TGT_STATIC = 2'b00, TGT_SDRAM = 2'b01, TGT_SCRATCH = 2'b10, TGT_FABRIC = 2'b11} target_t;
	typedef enum logic [1:0] {WID_8 = 2'b00, WID_16 = 2'b01, WID_32 = 2'b10} width_t;
	typedef enum logic [1:0] {SZ_BYTE = 2'b00, SZ_HALF = 2'b01, SZ_WORD = 2'b10} size_t;
	typedef enum logic [1:0] {K_FETCH = 2'b00, K_DATA = 2'b01, K_FILL = 2'b10, K_DMA = 2'b11} kind_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_TURN = 2'b01, ST_BUSY = 2'b10} state_t;
endpackage

//--- xmem_lat_if.sv
// request bundle carried from the top into the latency calculator
`timescale 1ns/1ps
interface xmem_lat_if;
	import xmem_lat_pkg::*;
	kind_t       kind;
	target_t     target;
	width_t      width;
	size_t       size;
	logic        write;
	logic        seq;
	logic        dma_buf;
	logic        dma_first;
	logic        pipe;
	logic [3:0]  acc_t;
	logic [7:0]  cycles;
	modport calc (input kind, target, width, size, write, seq, dma_buf, dma_first, pipe, acc_t, output cycles);
	modport user (output kind, target, width, size, write, seq, dma_buf, dma_first, pipe, acc_t, input cycles);
endinterface

//--- xmem_lat_calc.sv
// combinational bus-cycle count for one external memory access
`timescale 1ns/1ps
module xmem_lat_calc #(
	parameter logic [7:0] DMA_INIT_LAT = 8'h02
) (
	xmem_lat_if.calc r
);
	import xmem_lat_pkg::*;
	logic [7:0] t;
	logic [7:0] base;
	logic       piped;

	always_comb
	begin
		t = {4'h0, r.acc_t};
		base = 8'h01;
		piped = 1'b0;
		case (r.kind)
			K_FILL:
			begin
				piped = 1'b1;
				if (r.target == TGT_SDRAM)
				begin
					case (r.width)
						WID_8:   base = SD_FILL_W8;
						WID_16:  base = SD_FILL_W16;
						default: base = SD_FILL_W32;
					endcase
				end
				else
				begin
					case (r.width)
						WID_8:   base = FILL_BASE + 8'(t << 4);
						WID_16:  base = FILL_BASE + 8'(t << 3);
						default: base = FILL_BASE + 8'(t << 2);
					endcase
				end
			end
			K_DMA:
			begin
				if (r.target == TGT_SCRATCH)
					base = 8'h01;
				else if (r.dma_buf)
					base = r.dma_first ? 8'h01 + DMA_INIT_LAT : 8'h01;
				else
					base = 8'h01 + DMA_WAIT;
			end
			default:
			begin
				// code fetches and data accesses to external memory both pay the extra stage
				piped = (r.target == TGT_STATIC || r.target == TGT_SDRAM);
				if (r.target == TGT_SDRAM)
				begin
					if (r.write)
						base = SD_WR;
					else
					begin
						// request, command, then two cycles of read data latency
						case ({r.size, r.width})
							{SZ_WORD, WID_8}:  base = SD_RD_W8;
							{SZ_WORD, WID_16}: base = SD_RD_W16;
							{SZ_HALF, WID_8}:  base = SD_RD_H8;
							default:           base = SD_RD_W32;
						endcase
					end
				end
				else if (r.target == TGT_STATIC)
				begin
					case ({r.size, r.width})
						{SZ_WORD, WID_8}:  base = 8'(t << 2);
						{SZ_WORD, WID_16}: base = 8'(t << 1);
						{SZ_HALF, WID_8}:  base = 8'(t << 1);
						default:           base = t;
					endcase
					if (!r.seq)
						base = base + NONSEQ_EXTRA;
				end
				else
					base = 8'h01;
			end
		endcase
		r.cycles = (piped && r.pipe) ? base + PIPE_EXTRA : base;
	end
endmodule

//--- xmem_lat.sv
// external memory access latency sequencer
//
// What this block does
// - At 40 MHz or more an extra stage sits before external memory.
// - That stage lengthens only cache fills and external code and data accesses.
// - 32-bit single-cycle static: non-sequential 2 (3 piped), sequential or multiple 1 (2).
// - 32-bit SDRAM same page: read 4 (5), write 2 (3).
// - SDRAM read: request, command, then two data latency cycles.
// - Cache fills come only from external memory.
// - Cacheable only in the SDRAM and flash region, not in its aliases.
// - Fabric or external-request memory never fills the cache.
// - Cache lines are four 32-bit words.
// - 32-bit single-cycle static fill takes 7 cycles, 8 piped.
// - Static fill takes 3+16t, 3+8t or 3+4t, plus one piped.
// - SDRAM fill takes 21, 13 or 9, plus one piped.
// - Static word fetch 4t, 2t or t; non-sequential +1, piped +1.
// - SDRAM word read 7, 5 or 4; writes 2; piped +1.
// - Unbuffered DMA to external memory has one wait state.
// - DMA to scratchpad finishes each transaction in one cycle.
// - Buffered DMA static reads: one cycle each after initial latency.
// - Buffered DMA SDRAM writes: one cycle each after initial latency.
// - Read then write to the same memory inserts one idle cycle.
`timescale 1ns/1ps
module xmem_lat #(
	parameter int unsigned CLK_HZ       = xmem_lat_pkg::SYS_CLK_HZ,
	parameter logic [7:0]  DMA_INIT_LAT = 8'h02
) (
	input  wire logic                   CLK_IN,
	input  wire logic                   RST_IN,
	input  wire logic                   REQ_VALID_IN,
	output logic                        REQ_READY_OUT,
	input  wire xmem_lat_pkg::kind_t    REQ_KIND_IN,
	input  wire logic [31:0]            REQ_ADDR_IN,
	input  wire logic                   REQ_WRITE_IN,
	input  wire logic                   REQ_SEQ_IN,
	input  wire xmem_lat_pkg::size_t    REQ_SIZE_IN,
	input  wire logic [1:0]             REQ_DMA_CH_IN,
	input  wire logic                   REQ_DMA_BUF_IN,
	input  wire logic                   REQ_FABRIC_IN,
	input  wire xmem_lat_pkg::width_t   STATIC_WIDTH_IN,
	input  wire xmem_lat_pkg::width_t   SDRAM_WIDTH_IN,
	input  wire logic [3:0]             STATIC_ACC_T_IN,
	input  wire logic [3:0]             SCRATCH_REGION_IN,
	output logic                        MEM_START_OUT,
	output logic                        MEM_IDLE_OUT,
	output logic                        CACHEABLE_OUT,
	output logic                        FILL_REFUSED_OUT,
	output logic [1:0]                  FILL_WORD_OUT,
	output logic                        PIPE_ON_OUT,
	output logic [7:0]                  CYCLES_OUT,
	output logic                        DONE_OUT
);
	import xmem_lat_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		state_t     st;
		logic [7:0] cnt;
		logic [7:0] total;
		logic       last_rd;
		target_t    last_tgt;
		logic       have_last;
		logic [3:0] ch_started;
		logic       done;
		logic       start;
		logic       cacheable;
		logic       refused;
		logic [1:0] fill_word;
		logic       is_fill;
		logic       pend_valid;
		logic       pend_write;
		target_t    pend_tgt;
	} regs_t;

	regs_t      s_q;
	regs_t      s_d;
	xmem_lat_if lat ();

	// fixed at elaboration: the clock rate decides whether the extra stage exists
	localparam logic PIPE_ON = (CLK_HZ >= PIPE_THRESH_HZ);

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	target_t tgt;
	logic    in_cache_rgn;
	logic    fill_ok;

	always_comb
	begin
		// only the base window is decoded; an alias map would fold onto it here
		in_cache_rgn = (REQ_ADDR_IN >= CACHE_LO) && (REQ_ADDR_IN < CACHE_HI);
		if (REQ_FABRIC_IN)
			tgt = TGT_FABRIC;
		else if (REQ_ADDR_IN[31:28] == SCRATCH_REGION_IN)
			tgt = TGT_SCRATCH;
		else if (REQ_ADDR_IN[31:28] == 4'hc)
			tgt = TGT_SDRAM;
		else
			tgt = TGT_STATIC;
		// fills only from external memory, never fabric or scratchpad
		fill_ok = in_cache_rgn && !REQ_FABRIC_IN && (tgt == TGT_SDRAM || tgt == TGT_STATIC);
	end

	assign lat.kind      = REQ_KIND_IN;
	assign lat.target    = tgt;
	assign lat.width     = (tgt == TGT_SDRAM) ? SDRAM_WIDTH_IN : STATIC_WIDTH_IN;
	assign lat.size      = (REQ_KIND_IN == K_FILL) ? SZ_WORD : REQ_SIZE_IN;
	assign lat.write     = REQ_WRITE_IN;
	assign lat.seq       = REQ_SEQ_IN;
	assign lat.dma_buf   = REQ_DMA_BUF_IN;
	assign lat.dma_first = !s_q.ch_started[REQ_DMA_CH_IN];
	assign lat.pipe      = PIPE_ON;
	assign lat.acc_t     = (STATIC_ACC_T_IN == 4'h0) ? 4'h1 : STATIC_ACC_T_IN;

	xmem_lat_calc #(
		.DMA_INIT_LAT (DMA_INIT_LAT)
	) u_calc (
		.r (lat.calc)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	logic ext_tgt;
	logic need_turn;
	logic accept;

	assign ext_tgt       = (tgt == TGT_SDRAM || tgt == TGT_STATIC);
	// idle cycle between a read and a following write on the same memory
	assign need_turn     = s_q.have_last && s_q.last_rd && REQ_WRITE_IN && ext_tgt
		&& tgt == s_q.last_tgt && REQ_KIND_IN != K_FILL;
	assign REQ_READY_OUT = (s_q.st == ST_IDLE) && !RST_IN;
	assign accept        = REQ_VALID_IN && REQ_READY_OUT;

	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.start = 1'b0;
		case (s_q.st)
			ST_IDLE:
			begin
				if (accept)
				begin
					s_d.cacheable = fill_ok;
					s_d.fill_word = 2'b00;
					s_d.is_fill = (REQ_KIND_IN == K_FILL);
					if (REQ_KIND_IN == K_FILL && !fill_ok)
					begin
						s_d.refused = 1'b1;
						s_d.done = 1'b1;
						s_d.total = 8'h00;
					end
					else
					begin
						s_d.refused = 1'b0;
						s_d.total = lat.cycles;
						s_d.cnt = lat.cycles;
						if (REQ_KIND_IN == K_DMA && REQ_DMA_BUF_IN)
							s_d.ch_started[REQ_DMA_CH_IN] = 1'b1;
						if (need_turn)
						begin
							s_d.st = ST_TURN;
							s_d.total = lat.cycles + TURN_CYC;
						end
						else
						begin
							s_d.st = ST_BUSY;
							s_d.start = ext_tgt;
						end
						s_d.have_last = ext_tgt;
						s_d.last_rd = !REQ_WRITE_IN;
						s_d.last_tgt = tgt;
					end
				end
				else if (REQ_KIND_IN != K_DMA || !REQ_VALID_IN)
					s_d.ch_started = s_q.ch_started;
			end
			ST_TURN:
			begin
				s_d.st = ST_BUSY;
				s_d.start = 1'b1;
			end
			ST_BUSY:
			begin
				// fill words advance across the line as the count runs down
				if (s_q.is_fill && s_q.cacheable && s_q.fill_word != 2'(LINE_WORDS - 1))
					s_d.fill_word = s_q.fill_word + 2'b01;
				if (s_q.cnt <= 8'h01)
				begin
					s_d.st = ST_IDLE;
					s_d.done = 1'b1;
					s_d.cnt = 8'h00;
				end
				else
					s_d.cnt = s_q.cnt - 8'h01;
			end
			default:
				s_d.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN)
	begin
		if (RST_IN)
		begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign MEM_START_OUT    = s_q.start;
	assign MEM_IDLE_OUT     = (s_q.st == ST_TURN);
	assign CACHEABLE_OUT    = s_q.cacheable;
	assign FILL_REFUSED_OUT = s_q.refused;
	assign FILL_WORD_OUT    = s_q.fill_word;
	assign PIPE_ON_OUT      = PIPE_ON;
	assign CYCLES_OUT       = s_q.total;
	assign DONE_OUT         = s_q.done;
endmodule

//--- xmem_lat_checker.sv
// assertion checker for the external memory latency sequencer
`timescale 1ns/1ps
module xmem_lat_checker #(
	parameter int unsigned CLK_HZ = xmem_lat_pkg::SYS_CLK_HZ
) (
	input wire logic                 CLK_IN,
	input wire logic                 RST_IN,
	input wire logic                 REQ_VALID_IN,
	input wire logic                 REQ_READY_OUT,
	input wire xmem_lat_pkg::kind_t  REQ_KIND_IN,
	input wire logic [31:0]          REQ_ADDR_IN,
	input wire logic                 REQ_FABRIC_IN,
	input wire xmem_lat_pkg::width_t SDRAM_WIDTH_IN,
	input wire logic [3:0]           SCRATCH_REGION_IN,
	input wire logic                 MEM_IDLE_OUT,
	input wire logic                 MEM_START_OUT,
	input wire logic                 FILL_REFUSED_OUT,
	input wire logic [1:0]           FILL_WORD_OUT,
	input wire logic                 PIPE_ON_OUT,
	input wire logic [7:0]           CYCLES_OUT,
	input wire logic                 DONE_OUT
);
	import xmem_lat_pkg::*;
	// ----------------------------------------
	// cycles since the last accepted request
	// ----------------------------------------
	localparam logic [7:0] PADD = (CLK_HZ >= PIPE_THRESH_HZ) ? 8'h01 : 8'h00;
	logic       tk;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	assign tk = REQ_VALID_IN && REQ_READY_OUT;
	// saturate so a stalled run cannot wrap into a false match
	assign cnt_d = tk ? 8'h01 : (cnt_q == 8'hff ? cnt_q : cnt_q + 8'h01);
	always_ff @(posedge CLK_IN)
		cnt_q <= RST_IN ? 8'h00 : cnt_d;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	pipe_flag_a: assert property (PIPE_ON_OUT == (CLK_HZ >= PIPE_THRESH_HZ))
		else $error("pipeline flag wrong for clock rate");
	count_match_a: assert property (DONE_OUT |-> cnt_q == CYCLES_OUT + 8'h01)
		else $error("done off the reported count");
	idle_start_a: assert property (MEM_IDLE_OUT |=> MEM_START_OUT && !MEM_IDLE_OUT)
		else $error("idle cycle not followed by start");
	range_refuse_a: assert property (tk && REQ_KIND_IN == K_FILL && (REQ_ADDR_IN < CACHE_LO || REQ_ADDR_IN >= CACHE_HI)
		|=> FILL_REFUSED_OUT && DONE_OUT && CYCLES_OUT == 8'h00)
		else $error("fill outside cacheable range not refused");
	fabric_refuse_a: assert property (tk && REQ_KIND_IN == K_FILL && REQ_FABRIC_IN |=> FILL_REFUSED_OUT)
		else $error("fabric fill not refused");
	sdram_fill_a: assert property (tk && REQ_KIND_IN == K_FILL && !REQ_FABRIC_IN && REQ_ADDR_IN[31:28] == 4'hc
		|=> CYCLES_OUT == (SDRAM_WIDTH_IN == WID_8 ? 8'h15 : SDRAM_WIDTH_IN == WID_16 ? 8'h0d : 8'h09) + PADD)
		else $error("sdram fill count wrong");
	fill_step_a: assert property ($changed(FILL_WORD_OUT) |-> FILL_WORD_OUT == $past(FILL_WORD_OUT) + 2'h1)
		else $error("fill word index skipped");
	scratch_dma_a: assert property (tk && REQ_KIND_IN == K_DMA && !REQ_FABRIC_IN && REQ_ADDR_IN[31:28] == SCRATCH_REGION_IN
		|=> CYCLES_OUT == 8'h01)
		else $error("scratchpad dma not single cycle");
	cover property (tk && REQ_KIND_IN == K_FILL);
	cover property (MEM_IDLE_OUT);
	cover property (FILL_REFUSED_OUT && DONE_OUT);
endmodule

//--- xmem_mem_model.sv
// external memory model: times each access from start to done
`timescale 1ns/1ps
module xmem_mem_model (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       start_in,
	input  wire logic       done_in,
	output logic [7:0]      span_out
);
	// ----------------------------------------
	// access span, page-hit timing only
	// ----------------------------------------
	logic [7:0] run_q;
	// code and each dma channel sit in their own bank, so no precharge here
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			run_q    <= 8'h00;
			span_out <= 8'h00;
		end
		else
		begin
			run_q <= done_in ? 8'h00 : (start_in ? 8'h01 : (run_q == 8'h00 ? 8'h00 : run_q + 8'h01));
			if (done_in)
				span_out <= run_q;
		end
	end
endmodule

//--- xmem_lat_tb.sv
// self-checking bench for the external memory latency sequencer
`timescale 1ns/1ps
module xmem_lat_tb;
	import xmem_lat_pkg::*;
	// ----------------------------------------
	// stimulus, dut and timing
	// ----------------------------------------
	logic        clk = 1'b0, rst = 1'b1, vld = 1'b0, wr = 1'b0, sq = 1'b0, bf = 1'b0, fab = 1'b0;
	logic        rdy, mst, mid, cch, rfs, pon, dn, idl, w3;
	kind_t       knd = K_FETCH;
	size_t       sz = SZ_WORD;
	width_t      sw = WID_32, dw = WID_32;
	logic [1:0]  ch = 2'h0, fw;
	logic [3:0]  at = 4'h1, scr = 4'h1;
	logic [31:0] adr = 32'h0;
	logic [7:0]  cyc, span;
	int          bad_count = 0, checked = 0, tmo = 0;
	logic        vld2 = 1'b0, rdy2, pon2, dn2;
	logic [7:0]  cyc2;
	always #50 clk = ~clk;
	xmem_lat #(.DMA_INIT_LAT(8'h02)) dut (
		.CLK_IN(clk), .RST_IN(rst), .REQ_VALID_IN(vld), .REQ_READY_OUT(rdy), .REQ_KIND_IN(knd),
		.REQ_ADDR_IN(adr), .REQ_WRITE_IN(wr), .REQ_SEQ_IN(sq), .REQ_SIZE_IN(sz), .REQ_DMA_CH_IN(ch),
		.REQ_DMA_BUF_IN(bf), .REQ_FABRIC_IN(fab), .STATIC_WIDTH_IN(sw), .SDRAM_WIDTH_IN(dw),
		.STATIC_ACC_T_IN(at), .SCRATCH_REGION_IN(scr), .MEM_START_OUT(mst), .MEM_IDLE_OUT(mid),
		.CACHEABLE_OUT(cch), .FILL_REFUSED_OUT(rfs), .FILL_WORD_OUT(fw), .PIPE_ON_OUT(pon),
		.CYCLES_OUT(cyc), .DONE_OUT(dn));
	xmem_mem_model mem (.clk_in(clk), .rst_in(rst), .start_in(mst), .done_in(dn), .span_out(span));
	// second sequencer at the threshold rate so the extra stage is exercised
	xmem_lat #(.CLK_HZ(PIPE_THRESH_HZ), .DMA_INIT_LAT(8'h02)) dut2 (
		.CLK_IN(clk), .RST_IN(rst), .REQ_VALID_IN(vld2), .REQ_READY_OUT(rdy2), .REQ_KIND_IN(knd),
		.REQ_ADDR_IN(adr), .REQ_WRITE_IN(wr), .REQ_SEQ_IN(sq), .REQ_SIZE_IN(sz), .REQ_DMA_CH_IN(ch),
		.REQ_DMA_BUF_IN(bf), .REQ_FABRIC_IN(fab), .STATIC_WIDTH_IN(sw), .SDRAM_WIDTH_IN(dw),
		.STATIC_ACC_T_IN(at), .SCRATCH_REGION_IN(scr), .MEM_START_OUT(), .MEM_IDLE_OUT(),
		.CACHEABLE_OUT(), .FILL_REFUSED_OUT(), .FILL_WORD_OUT(), .PIPE_ON_OUT(pon2),
		.CYCLES_OUT(cyc2), .DONE_OUT(dn2));
	always @(posedge clk)
	begin
		tmo <= tmo + 1;
		if (tmo == 5000)
		begin
			bad_count++;
			$display("CHECK FAILED %0t timeout", $time);
			end_sim();
		end
	end
	task automatic end_sim();
		if (bad_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk_n(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %0t count %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
	endtask
	// refused fills answer one cycle after the take, with a zero count
	task automatic acc(input kind_t k, input logic [31:0] a, input logic w, input logic [1:0] c, input logic [7:0] n);
		int t;
		knd <= k;
		adr <= a;
		wr <= w;
		ch <= c;
		vld <= 1'b1;
		@(posedge clk);
		while (rdy !== 1'b1)
			@(posedge clk);
		vld <= 1'b0;
		t = 0;
		idl = 1'b0;
		w3 = 1'b0;
		do
		begin
			@(posedge clk);
			t++;
			idl |= mid;
			w3 |= (fw == 2'h3);
		end
		while (dn !== 1'b1 && t < 60);
		chk_n(t[7:0], n + 8'h01);
		chk_n(cyc, n);
	endtask
	task automatic accp(input kind_t k, input logic [31:0] a, input logic w, input logic [7:0] n);
		int t;
		knd <= k;
		adr <= a;
		wr <= w;
		vld2 <= 1'b1;
		@(posedge clk);
		while (rdy2 !== 1'b1)
			@(posedge clk);
		vld2 <= 1'b0;
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (dn2 !== 1'b1 && t < 60);
		chk_n(t[7:0], n + 8'h01);
		chk_n(cyc2, n);
	endtask
	task automatic t_pipe();
		chk_b(pon2, 1'b1);
		accp(K_FETCH, 32'hd0000000, 1'b0, 8'h03);
		accp(K_DATA, 32'hc0000000, 1'b1, 8'h03);
		accp(K_DATA, 32'hc0000000, 1'b0, 8'h05);
		accp(K_DATA, 32'hc0000000, 1'b1, 8'h04);
		accp(K_FILL, 32'hd0000100, 1'b0, 8'h08);
		accp(K_FILL, 32'hc0000100, 1'b0, 8'h0a);
		accp(K_DMA, 32'hc0000080, 1'b0, 8'h02);
	endtask
	task automatic t_static();
		acc(K_FETCH, 32'hd0000000, 1'b0, 2'h0, 8'h02);
		sq <= 1'b1;
		acc(K_FETCH, 32'hd0000004, 1'b0, 2'h0, 8'h01);
		sw <= WID_8;
		at <= 4'h3;
		acc(K_FETCH, 32'hd0000008, 1'b0, 2'h0, 8'h0c);
		sq <= 1'b0;
		acc(K_FETCH, 32'hd0000010, 1'b0, 2'h0, 8'h0d);
		sw <= WID_16;
		acc(K_FETCH, 32'hd0000020, 1'b0, 2'h0, 8'h07);
	endtask
	task automatic t_sdram();
		acc(K_DATA, 32'hc0000000, 1'b1, 2'h0, 8'h02);
		acc(K_DATA, 32'hc0000000, 1'b0, 2'h0, 8'h04);
		@(posedge clk);
		chk_n(span, 8'h04);
		acc(K_DATA, 32'hc0000010, 1'b0, 2'h0, 8'h04);
		acc(K_DATA, 32'hc0000010, 1'b1, 2'h0, 8'h03);
		@(posedge clk);
		chk_b(idl, 1'b1);
		chk_n(span, 8'h02);
		dw <= WID_8;
		acc(K_DATA, 32'hc0000020, 1'b0, 2'h0, 8'h07);
		sz <= SZ_HALF;
		acc(K_DATA, 32'hc0000020, 1'b0, 2'h0, 8'h05);
		sz <= SZ_WORD;
		dw <= WID_16;
		acc(K_DATA, 32'hc0000020, 1'b0, 2'h0, 8'h05);
	endtask
	task automatic t_fill();
		sw <= WID_32;
		at <= 4'h1;
		acc(K_FILL, 32'hd0000100, 1'b0, 2'h0, 8'h07);
		chk_b(w3, 1'b1);
		chk_b(cch, 1'b1);
		sw <= WID_16;
		at <= 4'h2;
		acc(K_FILL, 32'hd0000200, 1'b0, 2'h0, 8'h13);
		sw <= WID_8;
		acc(K_FILL, 32'hd0000300, 1'b0, 2'h0, 8'h23);
		acc(K_FILL, 32'hc0000100, 1'b0, 2'h0, 8'h0d);
		dw <= WID_8;
		acc(K_FILL, 32'hc0000200, 1'b0, 2'h0, 8'h15);
		dw <= WID_32;
		acc(K_FILL, 32'hc0000300, 1'b0, 2'h0, 8'h09);
	endtask
	task automatic t_refuse();
		acc(K_FILL, 32'h10000000, 1'b0, 2'h0, 8'h00);
		chk_b(rfs, 1'b1);
		acc(K_FILL, 32'hd1000000, 1'b0, 2'h0, 8'h00);
		chk_b(cch, 1'b0);
		acc(K_FILL, 32'hbffffffc, 1'b0, 2'h0, 8'h00);
		fab <= 1'b1;
		acc(K_FILL, 32'hc0000040, 1'b0, 2'h0, 8'h00);
		chk_b(rfs, 1'b1);
		fab <= 1'b0;
	endtask
	task automatic t_dma();
		sw <= WID_32;
		at <= 4'h1;
		acc(K_DMA, 32'hc0000080, 1'b0, 2'h0, 8'h02);
		acc(K_DMA, 32'hd0000080, 1'b0, 2'h1, 8'h02);
		acc(K_DMA, 32'h10000080, 1'b1, 2'h2, 8'h01);
		do_reset();
		bf <= 1'b1;
		for (int i = 0; i < 4; i++)
			acc(K_DMA, 32'hd0000000, 1'b0, i[1:0], 8'h03);
		acc(K_DMA, 32'hd0000004, 1'b0, 2'h0, 8'h01);
		do_reset();
		acc(K_DMA, 32'hc0000000, 1'b1, 2'h1, 8'h03);
		acc(K_DMA, 32'hc0000004, 1'b1, 2'h1, 8'h01);
	endtask
	initial
	begin
		do_reset();
		chk_b(pon, 1'b0);
		t_pipe();
		t_static();
		t_sdram();
		t_fill();
		t_refuse();
		t_dma();
		end_sim();
	end
endmodule
bind xmem_lat xmem_lat_checker #(.CLK_HZ(CLK_HZ)) chk (
	.CLK_IN(CLK_IN), .RST_IN(RST_IN), .REQ_VALID_IN(REQ_VALID_IN), .REQ_READY_OUT(REQ_READY_OUT),
	.REQ_KIND_IN(REQ_KIND_IN), .REQ_ADDR_IN(REQ_ADDR_IN), .REQ_FABRIC_IN(REQ_FABRIC_IN),
	.SDRAM_WIDTH_IN(SDRAM_WIDTH_IN), .SCRATCH_REGION_IN(SCRATCH_REGION_IN), .MEM_IDLE_OUT(MEM_IDLE_OUT),
	.MEM_START_OUT(MEM_START_OUT), .FILL_REFUSED_OUT(FILL_REFUSED_OUT), .FILL_WORD_OUT(FILL_WORD_OUT),
	.PIPE_ON_OUT(PIPE_ON_OUT), .CYCLES_OUT(CYCLES_OUT), .DONE_OUT(DONE_OUT));
